// ==== pkg/eprom_lock_pkg.sv ====
// Constants, register map and mode encoding for the OTP programming and lock block
package eprom_lock_pkg;

	// Storage geometry
	localparam int CODE_ADDR_W = 14;
	localparam int CODE_DEPTH  = 16384;
	localparam int KEY_ADDR_W  = 6;
	localparam int KEY_DEPTH   = 64;
	localparam int BYTE_W      = 8;

	// Register port geometry
	localparam int BUS_ADDR_W  = 4;
	localparam int BUS_DATA_W  = 32;

	// Register offsets
	localparam logic [3:0] REG_CONTROL    = 4'h0;
	localparam logic [3:0] REG_TABLE_ADDR = 4'h4;
	localparam logic [3:0] REG_TABLE_DATA = 4'h8;
	localparam logic [3:0] REG_STATUS     = 4'hC;

	// Field positions
	localparam int CTRL_RUN_EXTERNAL = 0;
	localparam int ST_LOCK_ONE       = 0;
	localparam int ST_LOCK_TWO       = 1;
	localparam int ST_LOCK_THREE     = 2;
	localparam int ST_SIX_CLOCK      = 3;
	localparam int ST_EA_LATCHED     = 4;
	localparam int ST_REFUSED        = 5;
	localparam int ST_BAD_PULSE      = 6;

	// Port 0 bit positions during verify
	localparam int P0_LOCK_ONE   = 7;
	localparam int P0_LOCK_TWO   = 6;
	localparam int P0_LOCK_THREE = 3;
	localparam int P0_CLOCK_MODE = 4;

	// Reset and blank values
	localparam logic [7:0]  OTP_BLANK       = 8'hFF;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
	localparam logic [13:0] TABLE_ADDR_INIT = 14'h0000;
	// Signature byte, value is arbitrary
	localparam logic [7:0]  SIGNATURE_BYTE  = 8'h5A;

	// Strobe timing
	localparam int CLK_MHZ           = 40;
	localparam int PULSE_LOW_US      = 100;
	localparam int PULSE_TOL_US      = 10;
	localparam int PULSE_HIGH_MIN_US = 10;
	localparam int PULSES_PER_ITEM   = 5;
	localparam logic [11:0] PULSE_LOW_MIN_CYCLES  = 12'((PULSE_LOW_US - PULSE_TOL_US) * CLK_MHZ);
	localparam logic [11:0] PULSE_HIGH_MIN_CYCLES = 12'(PULSE_HIGH_MIN_US * CLK_MHZ);

	// Programming and verify modes
	typedef enum logic [3:0] {
		MODE_IDLE,
		MODE_READ_SIGNATURE,
		MODE_PROGRAM_CODE,
		MODE_VERIFY_CODE,
		MODE_PROGRAM_KEY,
		MODE_PROGRAM_LOCK_ONE,
		MODE_PROGRAM_LOCK_TWO,
		MODE_PROGRAM_LOCK_THREE,
		MODE_PROGRAM_SIX_CLOCK,
		MODE_VERIFY_SIX_CLOCK,
		MODE_VERIFY_LOCKS
	} mode_type;

endpackage

// ==== rtl/otp_store.sv ====
// One-time-programmable byte store with registered read data
`timescale 1ns/100ps
module otp_store
	import eprom_lock_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int DEPTH  = 64
) (
	// Clock
	input  wire logic              clk,
	// Access
	input  wire logic              write_en,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	output logic      [7:0]        rdata
);

	// Storage cells, a blank part reads all ones
	logic [7:0] cells [DEPTH] = '{default: OTP_BLANK};

	// Programming can only clear bits
	always_ff @(posedge clk) begin
		if (write_en) begin
			cells[addr] <= cells[addr] & wdata;
		end
	end

	// Registered read
	always_ff @(posedge clk) begin
		rdata <= cells[addr];
	end

endmodule

// ==== rtl/eprom_program_and_lock.sv ====
// Parallel programming port, verify paths and lock protection of the code store
`timescale 1ns/100ps
module eprom_program_and_lock
	import eprom_lock_pkg::*;
(
	// Clock and reset
	input  wire logic                  CLK,
	input  wire logic                  RESETN,
	// Register port
	input  wire logic [BUS_ADDR_W-1:0] REG_ADDR,
	input  wire logic [BUS_DATA_W-1:0] REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output logic      [BUS_DATA_W-1:0] REG_RDATA,
	// Programmer pins
	input  wire logic                  DEVICE_RESET,
	input  wire logic                  CODE_FETCH_STROBE,
	input  wire logic                  LATCH_STROBE_PROGRAM_PULSE,
	input  wire logic                  EXTERNAL_ACCESS_PROGRAM_VOLTAGE,
	input  wire logic                  PROGRAM_VOLTAGE_PRESENT,
	input  wire logic                  P2_7,
	input  wire logic                  P2_6,
	input  wire logic                  P3_7,
	input  wire logic                  P3_6,
	input  wire logic                  P3_3,
	input  wire logic [CODE_ADDR_W-1:0] PROG_ADDR,
	// Port 0 data pins
	input  wire logic [7:0]            P0_IN,
	output logic      [7:0]            P0_OUT,
	output logic                       P0_OE_N,
	// Core-side protection outputs
	output logic                       EXTERNAL_ACCESS_SELECT,
	output logic                       EXTERNAL_EXEC_BLOCK,
	output logic                       RAM_ACCESS_BLOCK,
	output logic                       SIX_CLOCK_MODE
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	// Nonvolatile option bits, blank at power-up, survive RESETN
	logic                   lock_one = 1'b0;
	logic                   lock_two = 1'b0;
	logic                   lock_three = 1'b0;
	logic                   six_clock = 1'b0;
	// Effective protection levels
	logic                   lock_two_eff;
	logic                   lock_three_eff;
	// Decoded mode and strobe tracking
	mode_type               mode;
	logic                   strobe_prev;
	logic [11:0]            low_count;
	logic [11:0]            high_count;
	logic                   high_ok;
	logic                   program_pulse;
	logic                   bad_pulse;
	// Store access
	logic                   code_we;
	logic                   key_we;
	logic [CODE_ADDR_W-1:0] store_addr;
	logic [7:0]             code_rdata;
	logic [7:0]             key_rdata;
	logic [7:0]             verify_byte;
	// Software state
	logic                   run_external;
	logic [CODE_ADDR_W-1:0] table_addr;
	logic                   table_go;
	logic                   table_load;
	logic                   table_deny;
	logic [7:0]             table_data;
	logic                   refused;
	logic                   ea_latched;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode

	// Pin pattern to mode; program modes need the high voltage
	function automatic mode_type decode_mode(
		input logic rst, input logic fetch, input logic strobe, input logic vpp,
		input logic ea, input logic a, input logic b, input logic c, input logic d, input logic e);
		mode_type m;
		m = MODE_IDLE;
		if (rst && !fetch && vpp) begin
			// Program patterns, strobe is pulsing
			case ({a, b, c, d})
				4'b1011: m = MODE_PROGRAM_CODE;
				4'b1010: m = MODE_PROGRAM_KEY;
				4'b1111: m = MODE_PROGRAM_LOCK_ONE;
				4'b1100: m = MODE_PROGRAM_LOCK_TWO;
				4'b0101: m = MODE_PROGRAM_LOCK_THREE;
				4'b0010: m = e ? MODE_IDLE : MODE_PROGRAM_SIX_CLOCK;
				default: m = MODE_IDLE;
			endcase
		end else if (rst && !fetch && strobe && ea) begin
			// Verify patterns, first port bit ignored where marked
			if ({a, b, c, d} == 4'b0000) begin
				m = MODE_READ_SIGNATURE;
			end else if ({a, b, c, d} == 4'b0011) begin
				m = MODE_VERIFY_CODE;
			end else if ({b, c, d, e} == 4'b0011) begin
				m = MODE_VERIFY_SIX_CLOCK;
			end else if ({b, c, d} == 3'b010) begin
				m = MODE_VERIFY_LOCKS;
			end
		end
		return m;
	endfunction

	// Registered mode
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			mode <= MODE_IDLE;
		end else begin
			mode <= decode_mode(DEVICE_RESET, CODE_FETCH_STROBE, LATCH_STROBE_PROGRAM_PULSE,
				PROGRAM_VOLTAGE_PRESENT, EXTERNAL_ACCESS_PROGRAM_VOLTAGE, P2_7, P2_6, P3_7, P3_6, P3_3);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strobe pulse qualification

	// Previous strobe level
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			strobe_prev <= 1'b1;
		end else begin
			strobe_prev <= LATCH_STROBE_PROGRAM_PULSE;
		end
	end

	// Low and high time counters, saturating
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			low_count  <= 12'h000;
			high_count <= 12'h000;
			high_ok    <= 1'b0;
		end else if (LATCH_STROBE_PROGRAM_PULSE) begin
			low_count <= 12'h000;
			if (high_count != PULSE_HIGH_MIN_CYCLES) begin
				high_count <= high_count + 12'h001;
			end
		end else begin
			high_count <= 12'h000;
			// Falling edge: remember whether the high gap was long enough
			if (strobe_prev) begin
				high_ok <= (high_count == PULSE_HIGH_MIN_CYCLES);
			end
			if (low_count != PULSE_LOW_MIN_CYCLES) begin
				low_count <= low_count + 12'h001;
			end
		end
	end

	// One pulse per qualified rising edge of the strobe
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			program_pulse <= 1'b0;
			bad_pulse     <= 1'b0;
		end else begin
			program_pulse <= 1'b0;
			if (LATCH_STROBE_PROGRAM_PULSE && !strobe_prev) begin
				// Short pulses or short gaps do not program
				if (high_ok && low_count == PULSE_LOW_MIN_CYCLES) begin
					program_pulse <= 1'b1;
				end else begin
					bad_pulse <= 1'b1;
				end
			end else if (REG_WR && REG_ADDR == REG_STATUS && REG_WDATA[ST_BAD_PULSE]) begin
				bad_pulse <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Nonvolatile option and lock bits

	// Lock bits only climb one level at a time
	always_ff @(posedge CLK) begin
		if (program_pulse) begin
			if (mode == MODE_PROGRAM_LOCK_ONE) begin
				lock_one <= 1'b1;
			end
			if (mode == MODE_PROGRAM_LOCK_TWO && lock_one) begin
				lock_two <= 1'b1;
			end
			if (mode == MODE_PROGRAM_LOCK_THREE && lock_two) begin
				lock_three <= 1'b1;
			end
			if (mode == MODE_PROGRAM_SIX_CLOCK && !lock_one) begin
				six_clock <= 1'b1;
			end
		end
	end

	// Higher levels count only on top of the lower ones
	assign lock_two_eff   = lock_one && lock_two;
	assign lock_three_eff = lock_two_eff && lock_three;

	////////////////////////////////////////////////////////////////////////////////
	// Code and encryption stores

	// Memory writes are dropped once lock one is set
	assign code_we = program_pulse && mode == MODE_PROGRAM_CODE && !lock_one;
	assign key_we  = program_pulse && mode == MODE_PROGRAM_KEY && !lock_one;

	// Pins own the address in any non-idle mode, software in idle
	assign store_addr = (mode == MODE_IDLE) ? table_addr : PROG_ADDR;

	// Encrypted verify byte; a blank key leaves code unchanged
	assign verify_byte = ~(code_rdata ^ key_rdata);

	// User code store
	otp_store #(
		.ADDR_W (CODE_ADDR_W),
		.DEPTH  (CODE_DEPTH)
	) u_code_store (
		.clk      (CLK),
		.write_en (code_we),
		.addr     (store_addr),
		.wdata    (P0_IN),
		.rdata    (code_rdata)
	);

	// Encryption key store
	otp_store #(
		.ADDR_W (KEY_ADDR_W),
		.DEPTH  (KEY_DEPTH)
	) u_key_store (
		.clk      (CLK),
		.write_en (key_we),
		.addr     (store_addr[KEY_ADDR_W-1:0]),
		.wdata    (P0_IN),
		.rdata    (key_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Port 0 verify output

	// Drive port 0 in read modes only
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			P0_OUT  <= BYTE_ZERO;
			P0_OE_N <= 1'b1;
		end else begin
			P0_OUT  <= BYTE_ZERO;
			P0_OE_N <= 1'b1;
			case (mode)
				// Code verify, shut off by an effective lock two
				MODE_VERIFY_CODE: begin
					if (!lock_two_eff) begin
						P0_OUT  <= verify_byte;
						P0_OE_N <= 1'b0;
					end
				end
				// Signature byte
				MODE_READ_SIGNATURE: begin
					P0_OUT  <= SIGNATURE_BYTE;
					P0_OE_N <= 1'b0;
				end
				// One means twelve-clock operation
				MODE_VERIFY_SIX_CLOCK: begin
					P0_OUT[P0_CLOCK_MODE] <= !six_clock;
					P0_OE_N               <= 1'b0;
				end
				// Raw lock bits
				MODE_VERIFY_LOCKS: begin
					P0_OUT[P0_LOCK_ONE]   <= lock_one;
					P0_OUT[P0_LOCK_TWO]   <= lock_two;
					P0_OUT[P0_LOCK_THREE] <= lock_three;
					P0_OE_N               <= 1'b0;
				end
				default: begin
					P0_OE_N <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Core-side protection

	// Access select caught while the device reset pin is high
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ea_latched <= 1'b0;
		end else if (DEVICE_RESET) begin
			ea_latched <= EXTERNAL_ACCESS_PROGRAM_VOLTAGE;
		end
	end

	// Protection outputs
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			EXTERNAL_ACCESS_SELECT <= 1'b0;
			EXTERNAL_EXEC_BLOCK    <= 1'b0;
			RAM_ACCESS_BLOCK       <= 1'b0;
			SIX_CLOCK_MODE         <= 1'b0;
		end else begin
			EXTERNAL_ACCESS_SELECT <= lock_one ? ea_latched : EXTERNAL_ACCESS_PROGRAM_VOLTAGE;
			EXTERNAL_EXEC_BLOCK    <= lock_three_eff;
			RAM_ACCESS_BLOCK       <= lock_three_eff;
			SIX_CLOCK_MODE         <= six_clock;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers

	// Control register
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			run_external <= 1'b0;
		end else if (REG_WR && REG_ADDR == REG_CONTROL) begin
			run_external <= REG_WDATA[CTRL_RUN_EXTERNAL];
		end
	end

	// Table read launch; denied from external code under lock one
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			table_addr <= TABLE_ADDR_INIT;
			table_go   <= 1'b0;
			table_deny <= 1'b0;
		end else begin
			table_go <= REG_WR && REG_ADDR == REG_TABLE_ADDR;
			if (REG_WR && REG_ADDR == REG_TABLE_ADDR) begin
				table_addr <= REG_WDATA[CODE_ADDR_W-1:0];
				table_deny <= (lock_one && run_external) || mode != MODE_IDLE;
			end
		end
	end

	// Read data lands one cycle after the address is applied
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			table_load <= 1'b0;
			table_data <= BYTE_ZERO;
		end else begin
			table_load <= table_go;
			if (table_load) begin
				table_data <= table_deny ? BYTE_ZERO : code_rdata;
			end
		end
	end

	// Sticky refusal flag, a new refusal beats the clear
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			refused <= 1'b0;
		end else if (table_go && table_deny) begin
			refused <= 1'b1;
		end else if (REG_WR && REG_ADDR == REG_STATUS && REG_WDATA[ST_REFUSED]) begin
			refused <= 1'b0;
		end
	end

	// Read data, zero for unmapped offsets
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			REG_RDATA <= '0;
		end else begin
			REG_RDATA <= '0;
			if (REG_RD) begin
				case (REG_ADDR)
					REG_CONTROL:    REG_RDATA[CTRL_RUN_EXTERNAL] <= run_external;
					REG_TABLE_ADDR: REG_RDATA[CODE_ADDR_W-1:0] <= table_addr;
					REG_TABLE_DATA: REG_RDATA[7:0] <= table_data;
					REG_STATUS: begin
						REG_RDATA[ST_LOCK_ONE]   <= lock_one;
						REG_RDATA[ST_LOCK_TWO]   <= lock_two;
						REG_RDATA[ST_LOCK_THREE] <= lock_three;
						REG_RDATA[ST_SIX_CLOCK]  <= six_clock;
						REG_RDATA[ST_EA_LATCHED] <= ea_latched;
						REG_RDATA[ST_REFUSED]    <= refused;
						REG_RDATA[ST_BAD_PULSE]  <= bad_pulse;
					end
					default: REG_RDATA <= '0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_six_clock_record;
		@(posedge CLK) disable iff (!RESETN)
		program_pulse && mode == MODE_PROGRAM_SIX_CLOCK && !lock_one |=> six_clock;
	endproperty
	a_six_clock_record: assert property (p_six_clock_record)
		else $error("six-clock option not recorded");

	property p_clock_mode_pin;
		@(posedge CLK) disable iff (!RESETN)
		mode == MODE_VERIFY_SIX_CLOCK |=> !P0_OE_N && P0_OUT[P0_CLOCK_MODE] == !$past(six_clock);
	endproperty
	a_clock_mode_pin: assert property (p_clock_mode_pin)
		else $error("clock mode not shown on port 0");

	property p_lock_pins;
		@(posedge CLK) disable iff (!RESETN)
		mode == MODE_VERIFY_LOCKS |=> !P0_OE_N && P0_OUT[P0_LOCK_ONE] == lock_one
			&& P0_OUT[P0_LOCK_TWO] == lock_two && P0_OUT[P0_LOCK_THREE] == lock_three;
	endproperty
	a_lock_pins: assert property (p_lock_pins)
		else $error("lock bits not shown on port 0");

	property p_verify_data;
		@(posedge CLK) disable iff (!RESETN)
		mode == MODE_VERIFY_CODE && !lock_two_eff |=> !P0_OE_N && P0_OUT == ~($past(code_rdata) ^ $past(key_rdata));
	endproperty
	a_verify_data: assert property (p_verify_data)
		else $error("verify byte not encrypted code");

	property p_table_refused;
		@(posedge CLK) disable iff (!RESETN)
		REG_WR && REG_ADDR == REG_TABLE_ADDR && lock_one && run_external |=> ##1 refused ##1 table_data == BYTE_ZERO;
	endproperty
	a_table_refused: assert property (p_table_refused)
		else $error("table read not refused");

	property p_verify_blocked;
		@(posedge CLK) disable iff (!RESETN)
		mode == MODE_VERIFY_CODE && lock_two_eff |=> P0_OE_N;
	endproperty
	a_verify_blocked: assert property (p_verify_blocked)
		else $error("verify not blocked by lock two");

	property p_exec_block;
		@(posedge CLK) disable iff (!RESETN)
		lock_three_eff |=> EXTERNAL_EXEC_BLOCK && RAM_ACCESS_BLOCK;
	endproperty
	a_exec_block: assert property (p_exec_block)
		else $error("lock three restrictions missing");

	property p_no_write_locked;
		@(posedge CLK) disable iff (!RESETN)
		lock_one && program_pulse |-> !code_we && !key_we ##1 $stable(six_clock);
	endproperty
	a_no_write_locked: assert property (p_no_write_locked)
		else $error("store written while locked");

	property p_ea_held;
		@(posedge CLK) disable iff (!RESETN)
		lock_one && !DEVICE_RESET && !$past(DEVICE_RESET) ##1 lock_one |-> EXTERNAL_ACCESS_SELECT == ea_latched;
	endproperty
	a_ea_held: assert property (p_ea_held)
		else $error("access select not latched");

endmodule

// ==== test/programmer_model.sv ====
// Behavioural parallel programmer driving the mode pins, address, data and strobe
`timescale 1ns/100ps
module programmer_model (
	// Clock
	input  wire logic        clk,
	// Mode pins
	output logic             dev_reset,
	output logic             fetch_strobe,
	output logic             prog_strobe,
	output logic             access_pin,
	output logic             vpp_on,
	// Select levels in order P2.7, P2.6, P3.7, P3.6, P3.3
	output logic [4:0]       sel,
	// Address and data
	output logic [13:0]      addr,
	output logic [7:0]       data
);
	// Pulse shape: 92.5 us low and 10.25 us high at 40 MHz
	localparam int LOW_CYCLES  = 3700;
	localparam int HIGH_CYCLES = 410;

	////////////////////////////////////////////////////////////////////////////////
	// Idle levels at time zero: not selected, strobe high
	initial begin
		dev_reset = 1'b0;
		fetch_strobe = 1'b0;
		prog_strobe = 1'b1;
		access_pin = 1'b1;
		vpp_on = 1'b0;
		sel = 5'h00;
		addr = 14'h0000;
		data = 8'hA5;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Static mode levels; a released data bus shows the inverse of its last value
	task automatic set_mode(input logic rst, input logic [4:0] s, input logic vpp,
		input logic [13:0] a, input logic [7:0] d, input logic drv);
		@(posedge clk);
		dev_reset <= rst;
		sel <= s;
		vpp_on <= vpp;
		addr <= a;
		data <= drv ? d : ~data;
	endtask

	// Access pin level seen at device reset
	task automatic set_access(input logic v);
		@(posedge clk);
		access_pin <= v;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Strobe train: high gap first, then n pulses of the given low length
	task automatic pulse(input int n, input int low);
		repeat (HIGH_CYCLES) @(posedge clk);
		repeat (n) begin
			prog_strobe <= 1'b0;
			repeat (low) @(posedge clk);
			prog_strobe <= 1'b1;
			repeat (HIGH_CYCLES) @(posedge clk);
		end
	endtask
endmodule

// ==== test/test_eprom_program_and_lock.sv ====
// Self-checking testbench for the programming port and lock protection block
`timescale 1ns/100ps
module test_eprom_program_and_lock;
	import eprom_lock_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Signals
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        dev_reset, fetch_strobe, prog_strobe, access_pin, vpp_on;
	logic [4:0]  sel;
	logic [13:0] addr;
	logic [7:0]  data, p0_out;
	logic        p0_oe_n, ea_sel, exec_block, ram_block, six_clock;
	int          mismatches = 0;
	int          total_checks = 0;
	logic [31:0] rd;

	// Clock at 25 ns
	initial begin
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Instances
	programmer_model prog (.clk(clk), .dev_reset(dev_reset), .fetch_strobe(fetch_strobe),
		.prog_strobe(prog_strobe), .access_pin(access_pin), .vpp_on(vpp_on), .sel(sel),
		.addr(addr), .data(data));
	eprom_program_and_lock DUT (.CLK(clk), .RESETN(resetn), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.DEVICE_RESET(dev_reset), .CODE_FETCH_STROBE(fetch_strobe),
		.LATCH_STROBE_PROGRAM_PULSE(prog_strobe), .EXTERNAL_ACCESS_PROGRAM_VOLTAGE(access_pin),
		.PROGRAM_VOLTAGE_PRESENT(vpp_on), .P2_7(sel[4]), .P2_6(sel[3]), .P3_7(sel[2]),
		.P3_6(sel[1]), .P3_3(sel[0]), .PROG_ADDR(addr), .P0_IN(data), .P0_OUT(p0_out),
		.P0_OE_N(p0_oe_n), .EXTERNAL_ACCESS_SELECT(ea_sel), .EXTERNAL_EXEC_BLOCK(exec_block),
		.RAM_ACCESS_BLOCK(ram_block), .SIX_CLOCK_MODE(six_clock));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the read edge
	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Table read with pins idle, control bit set to run from external memory
	task automatic table_read(input logic [13:0] a, output logic [31:0] d);
		prog.set_mode(1'b0, 5'h00, 1'b0, a, 8'h00, 1'b0);
		reg_write(REG_CONTROL, 32'h1);
		reg_write(REG_TABLE_ADDR, {18'h0, a});
		repeat (3) @(posedge clk);
		reg_read(REG_TABLE_DATA, d);
	endtask

	// Verify mode: pins set, output settles within four cycles
	task automatic verify(input logic [4:0] s, input logic [13:0] a);
		prog.set_mode(1'b1, s, 1'b0, a, 8'h00, 1'b0);
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic program_item(input logic [4:0] s, input logic [13:0] a, input logic [7:0] d, input int n);
		prog.set_mode(1'b1, s, 1'b1, a, d, 1'b1);
		prog.pulse(n, prog.LOW_CYCLES);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_blank();
		reg_read(REG_STATUS, rd);
		check("status locks", rd & 32'hF, 32'h0);
		reg_read(4'h2, rd);
		check("unmapped", rd, 32'h0);
		verify(5'b00110, 14'h0123);
		check("blank code", p0_out, 32'hFF);
		verify(5'b00011, 14'h0000);
		check("twelve clock", p0_out[P0_CLOCK_MODE], 1'b1);
		verify(5'b00100, 14'h0000);
		check("no locks", {p0_out[7], p0_out[6], p0_out[3]}, 32'h0);
	endtask

	task automatic t_bad_pulse();
		// Short pulse in key table mode must leave the key blank
		prog.set_mode(1'b1, 5'b10100, 1'b1, 14'h0300, 8'h00, 1'b1);
		prog.pulse(1, 200);
		reg_read(REG_STATUS, rd);
		check("bad pulse", rd[ST_BAD_PULSE], 1'b1);
		reg_write(REG_STATUS, 32'h40);
		reg_read(REG_STATUS, rd);
		check("bad pulse clear", rd[ST_BAD_PULSE], 1'b0);
		verify(5'b00110, 14'h0300);
		check("short pulse ignored", p0_out, 32'hFF);
	endtask

	task automatic t_code();
		program_item(5'b10110, 14'h0123, 8'h3C, PULSES_PER_ITEM);
		verify(5'b00110, 14'h0123);
		check("code verify", {p0_oe_n, p0_out}, 32'h03C);
		table_read(14'h0123, rd);
		check("table unlocked", rd, 32'h3C);
	endtask

	task automatic t_six_clock();
		program_item(5'b00100, 14'h0000, 8'h00, 1);
		verify(5'b00011, 14'h0000);
		check("six clock pin", p0_out[P0_CLOCK_MODE], 1'b0);
		check("six clock out", six_clock, 1'b1);
	endtask

	task automatic t_lock_one();
		program_item(5'b11111, 14'h0000, 8'h00, PULSES_PER_ITEM);
		verify(5'b00100, 14'h0000);
		check("lock one pin", {p0_out[7], p0_out[6], p0_out[3]}, 32'h4);
		program_item(5'b10110, 14'h0200, 8'h00, 1);
		verify(5'b00110, 14'h0200);
		check("program refused", {p0_oe_n, p0_out}, 32'h0FF);
		table_read(14'h0123, rd);
		check("table refused", rd, 32'h0);
		reg_read(REG_STATUS, rd);
		check("refused flag", rd[ST_REFUSED], 1'b1);
		prog.set_access(1'b1);
		prog.set_mode(1'b1, 5'h00, 1'b0, 14'h0000, 8'h00, 1'b0);
		repeat (4) @(posedge clk);
		#1 check("signature", p0_out, SIGNATURE_BYTE);
		prog.set_mode(1'b0, 5'h00, 1'b0, 14'h0000, 8'h00, 1'b0);
		prog.set_access(1'b0);
		repeat (4) @(posedge clk);
		check("access latched", ea_sel, 1'b1);
		prog.set_access(1'b1);
	endtask

	task automatic t_lock_two();
		program_item(5'b11000, 14'h0000, 8'h00, PULSES_PER_ITEM);
		verify(5'b00100, 14'h0000);
		check("lock two pin", {p0_out[7], p0_out[6], p0_out[3]}, 32'h6);
		verify(5'b00110, 14'h0123);
		check("verify off", p0_oe_n, 1'b1);
		check("exec open", {exec_block, ram_block}, 32'h0);
	endtask

	// Third level on top of two, then a mid-run reset keeps it
	task automatic t_lock_three();
		program_item(5'b01010, 14'h0000, 8'h00, PULSES_PER_ITEM);
		verify(5'b00100, 14'h0000);
		check("lock three pin", {p0_out[7], p0_out[6], p0_out[3]}, 32'h7);
		check("exec closed", {exec_block, ram_block}, 32'h3);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1 check("reset protection", {exec_block, ram_block}, 32'h0);
		reg_read(REG_STATUS, rd);
		check("locks kept", rd & 32'h7, 32'h7);
		check("exec after reset", {exec_block, ram_block}, 32'h3);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and hang guard
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1 check("reset drive", p0_oe_n, 1'b1);
		check("reset data", reg_rdata, 32'h0);
		t_blank();
		t_bad_pulse();
		t_code();
		t_six_clock();
		t_lock_one();
		t_lock_two();
		t_lock_three();
		end_of_test();
	end

	initial begin
		repeat (99000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule
